/* hdl/lzc_byte_scan.sv */
// Zero-bit scanner for one written byte, most significant bit first
`timescale 1ns/100ps
`default_nettype none

module ldz_byte_scan
  import ldz_pkg::*;
(
  input  wire logic [7:0] data_i,
  input  wire logic       seen_i,
  output logic      [3:0] zeros_o,
  output logic            found_o
);

  // Count zeros above the first one; nothing counts once a one was seen
  always_comb
  begin
    logic stop;
    stop    = seen_i;
    zeros_o = 4'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (!stop)
      begin
        if (data_i[i])
          stop = 1'b1;
        else
          zeros_o = zeros_o + 4'h1;
      end
    end
    found_o = |data_i;
  end

endmodule // ldz_byte_scan

`default_nettype wire

/* hdl/lzc_pkg.sv */
// Package with register map, field positions and reset values of the zero counter
package ldz_pkg;

  // Register addresses on the special-function-register bus
  localparam logic [7:0] LDZ_ADDR_PORT    = 8'h97;
  localparam logic [7:0] LDZ_ADDR_CONTROL = 8'h96;

  // Field positions in zero_count_control
  localparam int LDZ_BIT_CLEAR    = 0;
  localparam int LDZ_BIT_SEL_LOW  = 1;
  localparam int LDZ_BIT_SEL_HIGH = 2;
  localparam int LDZ_BIT_MODE     = 3;
  localparam int LDZ_BIT_OVERFLOW = 4;

  // Widths and reset values
  localparam int          LDZ_COUNT_W       = 32;
  localparam logic [7:0]  LDZ_PORT_RESET    = 8'h00;
  localparam logic [7:0]  LDZ_CONTROL_RESET = 8'h00;
  localparam logic [31:0] LDZ_COUNT_RESET   = 32'h0000_0000;

  // Byte-select codes of the two-bit field
  localparam logic [1:0] LDZ_SEL_BYTE0 = 2'h0;
  localparam logic [1:0] LDZ_SEL_BYTE3 = 2'h3;

endpackage : ldz_pkg

/* hdl/lzc_top.sv */
// Leading-zero counting unit on the special-function-register bus
//
// Contract
// - Each port write adds zeros preceding the first one bit since clear.
// - Bits of a written byte arrive most significant first.
// - After a one bit is written the count stays frozen until cleared.
// - Count is 32 bits; a port read returns one byte of it.
// - Two-bit byte-select field in the control register picks the byte.
// - Setting clear bit zeroes count and overflow; writing zero only stores it.
// - Any write to the counting port returns the clear bit to zero.
`timescale 1ns/100ps
`default_nettype none

module ldz_top
  import ldz_pkg::*;
#(
  parameter int COUNT_W = LDZ_COUNT_W
)
(
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_hit_o
);

  // Pick one byte of the count by the select code
  function automatic logic [7:0] byte_pick(input logic [31:0] cnt, input logic [1:0] sel);
    byte_pick = cnt[8*sel +: 8];
  endfunction

  // State
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic               seen_reg;
  logic               seen_next;
  logic               overflow_reg;
  logic               overflow_next;
  logic               clear_reg;
  logic               clear_next;
  logic [1:0]         sel_reg;
  logic [1:0]         sel_next;
  logic               mode_reg;
  logic               mode_next;
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;
  logic               hit_reg;
  logic               hit_next;

  // Decoded strobes
  logic       port_wr;
  logic       ctrl_wr;
  logic       port_rd;
  logic       ctrl_rd;
  logic [3:0] byte_zeros;
  logic       byte_found;
  logic [7:0] ctrl_view;

  assign port_wr = sfr_wr_i && (sfr_addr_i == LDZ_ADDR_PORT);
  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == LDZ_ADDR_CONTROL);
  assign port_rd = sfr_rd_i && (sfr_addr_i == LDZ_ADDR_PORT);
  assign ctrl_rd = sfr_rd_i && (sfr_addr_i == LDZ_ADDR_CONTROL);

  // Upper control bits are unused and read as zero
  assign ctrl_view = {3'h0, overflow_reg, mode_reg, sel_reg, clear_reg};

  // Scanner for the byte being written
  ldz_byte_scan u_scan
  (
    .data_i  (sfr_wdata_i),
    .seen_i  (seen_reg),
    .zeros_o (byte_zeros),
    .found_o (byte_found)
  );

  // Count, freeze and clear behaviour
  always_comb
  begin
    logic [COUNT_W:0] sum;
    sum           = {1'b0, count_reg} + {{(COUNT_W - 3){1'b0}}, byte_zeros};
    count_next    = count_reg;
    seen_next     = seen_reg;
    overflow_next = overflow_reg;
    clear_next    = clear_reg;
    sel_next      = sel_reg;
    mode_next     = mode_reg;
    if (port_wr)
    begin
      clear_next = 1'b0;
      if (!seen_reg)
      begin
        count_next = sum[COUNT_W-1:0];
        // Wrap is kept visible instead of saturating the count
        if (sum[COUNT_W])
          overflow_next = 1'b1;
        seen_next = byte_found;
      end
    end
    else if (ctrl_wr)
    begin
      clear_next = sfr_wdata_i[LDZ_BIT_CLEAR];
      sel_next   = {sfr_wdata_i[LDZ_BIT_SEL_HIGH], sfr_wdata_i[LDZ_BIT_SEL_LOW]};
      mode_next  = sfr_wdata_i[LDZ_BIT_MODE];
      // Only a set clear bit acts; writing zero just stores the bit
      if (sfr_wdata_i[LDZ_BIT_CLEAR])
      begin
        count_next    = LDZ_COUNT_RESET[COUNT_W-1:0];
        overflow_next = 1'b0;
        seen_next     = 1'b0;
      end
    end
  end

  // Read path, registered so outputs come from flops
  always_comb
  begin
    rdata_next = 8'h00;
    hit_next   = 1'b0;
    if (port_rd)
    begin
      rdata_next = byte_pick(count_reg, sel_reg);
      hit_next   = 1'b1;
    end
    else if (ctrl_rd)
    begin
      rdata_next = ctrl_view;
      hit_next   = 1'b1;
    end
  end

  // Register all state
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      count_reg    <= LDZ_COUNT_RESET[COUNT_W-1:0];
      seen_reg     <= 1'b0;
      overflow_reg <= LDZ_CONTROL_RESET[LDZ_BIT_OVERFLOW];
      clear_reg    <= LDZ_CONTROL_RESET[LDZ_BIT_CLEAR];
      sel_reg      <= LDZ_CONTROL_RESET[LDZ_BIT_SEL_HIGH:LDZ_BIT_SEL_LOW];
      mode_reg     <= LDZ_CONTROL_RESET[LDZ_BIT_MODE];
      rdata_reg    <= LDZ_PORT_RESET;
      hit_reg      <= 1'b0;
    end
    else
    begin
      count_reg    <= count_next;
      seen_reg     <= seen_next;
      overflow_reg <= overflow_next;
      clear_reg    <= clear_next;
      sel_reg      <= sel_next;
      mode_reg     <= mode_next;
      rdata_reg    <= rdata_next;
      hit_reg      <= hit_next;
    end
  end

  assign sfr_rdata_o = rdata_reg;
  assign sfr_hit_o   = hit_reg;

  // Checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_port_wr;
    sfr_wr_i && (sfr_addr_i == LDZ_ADDR_PORT);
  endsequence

  sequence s_port_rd;
    sfr_rd_i && (sfr_addr_i == LDZ_ADDR_PORT);
  endsequence

  sequence s_set_clear;
    sfr_wr_i && (sfr_addr_i == LDZ_ADDR_CONTROL) && sfr_wdata_i[LDZ_BIT_CLEAR];
  endsequence

  property p_count_adds;
    s_port_wr ##0 !seen_reg |=> count_reg == $past(count_reg) + {28'h0, $past(byte_zeros)};
  endproperty
  a_count_adds: assert property (p_count_adds)
    else $error("count did not add the leading zeros");

  property p_msb_first;
    s_port_wr ##0 (!seen_reg && sfr_wdata_i == 8'h10) |=> count_reg == $past(count_reg) + 32'h3 && seen_reg;
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("bit order of a byte not msb first");

  property p_frozen;
    s_port_wr ##0 seen_reg |=> $stable(count_reg) && $stable(overflow_reg);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("count changed after a one bit");

  property p_read_byte;
    s_port_rd |=> sfr_hit_o && sfr_rdata_o == byte_pick($past(count_reg), $past(sel_reg));
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("port read returned wrong byte");

  property p_sel_top;
    s_port_rd ##0 sel_reg == LDZ_SEL_BYTE3 |=> sfr_rdata_o == $past(count_reg[31:24]);
  endproperty
  a_sel_top: assert property (p_sel_top)
    else $error("select 3 did not give top byte");

  // A control write right after the clear may legally drop the bit, so only the next cycle is judged
  property p_clear;
    s_set_clear |=> count_reg == 32'h0 && !overflow_reg && !seen_reg && clear_reg;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear bit did not clear count");

  // Clear bit stays set until some write changes it
  property p_clear_hold;
    clear_reg && !sfr_wr_i |=> clear_reg;
  endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("clear bit dropped without a write");

  property p_clear_zero_idle;
    sfr_wr_i && sfr_addr_i == LDZ_ADDR_CONTROL && !sfr_wdata_i[LDZ_BIT_CLEAR]
      |=> $stable(count_reg) && $stable(overflow_reg) && !clear_reg;
  endproperty
  a_clear_zero_idle: assert property (p_clear_zero_idle)
    else $error("writing clear bit zero changed count");

  property p_auto_clear;
    s_port_wr |=> !clear_reg;
  endproperty
  a_auto_clear: assert property (p_auto_clear)
    else $error("clear bit not dropped on port write");

  property p_sel_low;
    s_port_rd ##0 sel_reg == LDZ_SEL_BYTE0 |=> sfr_rdata_o == $past(count_reg[7:0]);
  endproperty
  a_sel_low: assert property (p_sel_low)
    else $error("select 0 did not give low byte");

endmodule // ldz_top

`default_nettype wire

/* tb/leading_zero_counter_test.sv */
// Self-checking testbench of the leading-zero counting unit
`timescale 1ns/100ps
`default_nettype none

module leading_zero_counter_test;
  import ldz_pkg::*;

  logic       sys_clk;
  logic       sys_rst;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic       sfr_rd;
  logic [7:0] sfr_rdata;
  logic       sfr_hit;
  int         bad_count;
  int         cmp_count;

  ldz_top dut_u (
    .sys_clk_i   (sys_clk),
    .sys_rst_i   (sys_rst),
    .sfr_addr_i  (sfr_addr),
    .sfr_wr_i    (sfr_wr),
    .sfr_wdata_i (sfr_wdata),
    .sfr_rd_i    (sfr_rd),
    .sfr_rdata_o (sfr_rdata),
    .sfr_hit_o   (sfr_hit)
  );

  // 25 MHz core clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // One write, strobe dropped and a spare edge so the next call never re-raises it in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // Read answer stands one cycle only, so it is judged right after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hexp);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    sfr_rd = 1'b0;
    cmp_count++;
    if ({sfr_hit, sfr_rdata} !== {hexp, exp})
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, {sfr_hit, sfr_rdata}, {hexp, exp});
    end
    @(posedge sys_clk);
    #1;
  endtask

  // Values after reset, unmapped address ignored
  task automatic t_reset();
    rd(LDZ_ADDR_PORT, LDZ_PORT_RESET, 1'b1);
    rd(LDZ_ADDR_CONTROL, LDZ_CONTROL_RESET, 1'b1);
    rd(8'h95, 8'h00, 1'b0);
  endtask

  // Single one bit at every position, then frozen count
  task automatic t_order();
    for (int k = 0; k < 8; k++)
    begin
      wr(LDZ_ADDR_CONTROL, 8'h01);
      wr(LDZ_ADDR_PORT, 8'h01 << k);
      rd(LDZ_ADDR_PORT, 8'(7 - k), 1'b1);
    end
    rd(LDZ_ADDR_CONTROL, 8'h00, 1'b1);
    wr(LDZ_ADDR_PORT, 8'h00);
    wr(LDZ_ADDR_PORT, 8'h00);
    rd(LDZ_ADDR_PORT, 8'h00, 1'b1);
  endtask

  // Long run of zero bytes spread over two count bytes, read back by select
  task automatic t_select();
    logic [31:0] exp;
    exp = 32'h0000_0147;
    wr(LDZ_ADDR_CONTROL, 8'h01);
    for (int n = 0; n < 40; n++)
      wr(LDZ_ADDR_PORT, 8'h00);
    wr(LDZ_ADDR_PORT, 8'h01);
    wr(LDZ_ADDR_PORT, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wr(LDZ_ADDR_CONTROL, 8'(s << 1));
      rd(LDZ_ADDR_CONTROL, 8'(s << 1), 1'b1);
      rd(LDZ_ADDR_PORT, exp[8*s +: 8], 1'b1);
    end
    // Upper bits: mode kept, overflow read-only, top bits read zero
    wr(LDZ_ADDR_CONTROL, 8'hF8);
    rd(LDZ_ADDR_CONTROL, 8'h08, 1'b1);
  endtask

  // Reset in mid-run with count, mode and one-seen dirty; first read right after release
  task automatic t_midreset();
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    rd(LDZ_ADDR_CONTROL, LDZ_CONTROL_RESET, 1'b1);
    rd(LDZ_ADDR_PORT, LDZ_PORT_RESET, 1'b1);
    wr(LDZ_ADDR_PORT, 8'h04);
    rd(LDZ_ADDR_PORT, 8'h05, 1'b1);
  endtask

  // Clear with byte 1 selected, then a port write drops the clear bit and still counts
  task automatic t_clear();
    wr(LDZ_ADDR_CONTROL, 8'h03);
    rd(LDZ_ADDR_CONTROL, 8'h03, 1'b1);
    rd(LDZ_ADDR_PORT, 8'h00, 1'b1);
    wr(LDZ_ADDR_PORT, 8'h20);
    rd(LDZ_ADDR_CONTROL, 8'h02, 1'b1);
    wr(LDZ_ADDR_CONTROL, 8'h00);
    rd(LDZ_ADDR_PORT, 8'h02, 1'b1);
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence, reset held three cycles
  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    sys_rst   = 1'b1;
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_wdata = 8'h00;
    sfr_rd    = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_order();
    t_select();
    t_midreset();
    t_clear();
    summarize();
  end

endmodule // leading_zero_counter_test

`default_nettype wire
